// file: rtl/updn_counter.sv
// Eight-channel period and totalize counter, up/down on the even channels, with setpoint matching
//
// Implementation choices: the register offsets and the AHB-Lite interface to the registers.
`timescale 1ns/100ps
module updn_counter
   import updn_cnt_pkg::*;
#(
   parameter int NCH = 8,
   parameter int NSP = 16
) (
   // Clock and reset
   input  wire logic        hclk,
   input  wire logic        hresetn,
   // AHB-Lite slave
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output      logic        hreadyout,
   output      logic        hresp,
   output      logic [31:0] hrdata,
   // Channel input pins and scan pulse from the main unit
   input  wire logic [NCH-1:0] ch_in,
   input  wire logic           scan_begin_pulse,
   // Sample stream to the main unit
   output      logic           smp_valid,
   input  wire logic           smp_ready,
   output      sample_t        smp_data,
   // Markers and open-drain output port
   output      logic [NCH-1:0] channel_match_marker,
   output      logic [7:0]     dport_o,
   output      logic [7:0]     dport_oe_n
);
   localparam int CW = $clog2(NCH);
   localparam int SW = $clog2(NSP);
   ////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers
   logic [NCH:0] s1_q, s2_q, s3_q;
   logic [NCH-1:0] in_s, rise, fall;
   logic           scan_ev;
   // Two stages before use; third only for edge detection
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s1_q <= '0;
         s2_q <= '0;
         s3_q <= '0;
      end else begin
         s1_q <= {scan_begin_pulse, ch_in};
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end
   assign in_s    = s2_q[NCH-1:0];
   assign rise    = s2_q[NCH-1:0] & ~s3_q[NCH-1:0];
   assign fall    = ~s2_q[NCH-1:0] & s3_q[NCH-1:0];
   assign scan_ev = s2_q[NCH] & ~s3_q[NCH];
   ////////////////////////////////////////////////////////////////////////////
   // Register file and bus slave
   cfg_t        cfg_q [NCH];
   lim_t        lim_q [NCH*NSP];
   spc_t        spc_q [NCH*NSP];
   logic [NCH-1:0] osel_q, osel_d, mark_q, mark_d;
   logic [7:0]  dport_q, dport_d;
   logic        acq_q, acq_d, wr_q, wr_d, busy_q, busy_d;
   logic [11:0] wa_q, wa_d;
   logic [31:0] rd_q, rd_d;
   logic [31:0] hold_w [NCH];
   logic        addr_ph, do_wr;
   logic [CW-1:0] seq_q, seq_d;
   logic        m_hit, push, in_rdy;
   spc_t        m_spc;
   // Zero wait states, always OKAY
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   assign hrdata    = rd_q;
   assign addr_ph   = hsel & htrans[1] & hready;
   assign do_wr     = wr_q;
   // Read data is captured in the address phase so it leaves a flip-flop
   always_comb begin
      wa_d = addr_ph ? haddr[11:0] : wa_q;
      wr_d = addr_ph & hwrite;
      rd_d = rd_q;
      acq_d = do_wr & (wa_q == CTRL_OFS) & hwdata[ACQ_BIT];
      osel_d = (do_wr && wa_q == OSEL_OFS) ? hwdata[NCH-1:0] : osel_q;
      if (addr_ph && !hwrite) begin
         rd_d = 32'h0000_0000;
         if (haddr[11:0] == CTRL_OFS) begin
            rd_d[BUSY_BIT] = busy_q;
         end else if (haddr[11:0] == OSEL_OFS) begin
            rd_d[NCH-1:0] = osel_q;
         end else if (haddr[11:0] == DPORT_OFS) begin
            rd_d[7:0] = dport_q;
         end else if (haddr[11:0] == MARK_OFS) begin
            rd_d[NCH-1:0] = mark_q;
         end else if (haddr[11:8] == CFG_BASE[11:8] && haddr[7:6] == 2'h0) begin
            rd_d = cfg_q[haddr[CW+1:2]];
         end else if (haddr[11:8] == HOLD_BASE[11:8] && haddr[7:6] == 2'h1) begin
            rd_d = hold_w[haddr[CW+1:2]];
         end else if (haddr[11:9] == LIM_BASE[11:9]) begin
            rd_d = lim_q[haddr[CW+SW+1:2]];
         end else if (haddr[11:9] == SPC_BASE[11:9]) begin
            rd_d = spc_q[haddr[CW+SW+1:2]];
         end
      end
   end
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wa_q   <= 12'h000;
         wr_q   <= 1'b0;
         rd_q   <= 32'h0000_0000;
         acq_q  <= 1'b0;
         osel_q <= '0;
      end else begin
         wa_q   <= wa_d;
         wr_q   <= wr_d;
         rd_q   <= rd_d;
         acq_q  <= acq_d;
         osel_q <= osel_d;
      end
   end
   // Config and setpoint tables, written in the data phase
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         for (int k = 0; k < NCH; k++) begin
            cfg_q[k] <= '0;
         end
         for (int k = 0; k < NCH*NSP; k++) begin
            lim_q[k] <= '0;
            spc_q[k] <= '0;
         end
      end else if (do_wr) begin
         if (wa_q[11:8] == CFG_BASE[11:8] && wa_q[7:6] == 2'h0) begin
            cfg_q[wa_q[CW+1:2]] <= hwdata;
         end
         if (wa_q[11:9] == LIM_BASE[11:9]) begin
            lim_q[wa_q[CW+SW+1:2]] <= hwdata;
         end
         if (wa_q[11:9] == SPC_BASE[11:9]) begin
            spc_q[wa_q[CW+SW+1:2]] <= {13'h0000, hwdata[18:0]};
         end
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   // Per-channel counters
   for (genvar i = 0; i < NCH; i++) begin : g_ch
      logic [31:0] cnt_q, cnt_d, per_q, per_d, hold_q, hold_d, top;
      logic [11:0] tdiv_q, tdiv_d, tlen;
      logic        dir, dedge, src, clr, ev, tick;
      // Direction comes from the odd neighbour of an even channel
      if ((i % 2) == 0 && i + 1 < NCH) begin : g_dir
         assign dir   = in_s[i+1];
         assign dedge = rise[i+1] | fall[i+1];
      end else begin : g_nodir
         assign dir   = 1'b0;
         assign dedge = 1'b0;
      end
      assign src  = cfg_q[i].map_sel[3] ? mark_q[cfg_q[i].map_sel[CW-1:0]]
                                        : in_s[cfg_q[i].map_sel[CW-1:0]];
      assign top  = cfg_q[i].wide ? 32'hFFFF_FFFF : 32'h0000_FFFF;
      assign tlen = (cfg_q[i].tick_sel == 2'h0) ? 12'(TICK0_CYC) :
                    (cfg_q[i].tick_sel == 2'h1) ? 12'(TICK1_CYC) : 12'(TICK2_CYC);
      assign tick = (tdiv_q >= tlen - 12'h001);
      // Edge multiplier: 1X rising, 2X both edges, 4X both edges of both lines
      assign ev   = (cfg_q[i].mult == MULT_1X) ? rise[i] :
                    (rise[i] | fall[i] | ((cfg_q[i].mult == MULT_2X) ? 1'b0 : dedge));
      always_comb begin
         cnt_d  = cnt_q;
         per_d  = per_q;
         tdiv_d = tdiv_q;
         hold_d = hold_q;
         clr    = 1'b0;
         case (cfg_q[i].mode)
            MODE_ENC: begin
               clr = cfg_q[i].clr_map & src;
               if (clr) begin
                  cnt_d = 32'h0000_0000;
               end else if (ev && (i % 2) == 0) begin
                  // Runs on between samples, so fast edges overshoot the limit
                  cnt_d = (dir ? cnt_q - 32'h0000_0001
                               : cnt_q + 32'h0000_0001) & top;
               end
            end
            MODE_PER: begin
               // Single-cycle period: ticks counted between rising edges
               tdiv_d = tick ? 12'h000 : tdiv_q + 12'h001;
               if (rise[i]) begin
                  per_d  = cnt_q;
                  cnt_d  = 32'h0000_0000;
                  tdiv_d = 12'h000;
               end else if (tick && (!cfg_q[i].gate_en || src) && cnt_q != top) begin
                  cnt_d = cnt_q + 32'h0000_0001;
               end
            end
            MODE_TOT: begin
               if (rise[i] && !(cfg_q[i].stop_top && cnt_q == top)) begin
                  cnt_d = (cnt_q + 32'h0000_0001) & top;
               end
            end
            default: cnt_d = 32'h0000_0000;
         endcase
         // Snapshot on scan begin; without latching the holding value follows
         if (scan_ev || !cfg_q[i].latch_en) begin
            hold_d = (cfg_q[i].mode == MODE_PER) ? per_q : cnt_q;
         end
         if (acq_q) begin
            cnt_d  = 32'h0000_0000;
            per_d  = 32'h0000_0000;
            tdiv_d = 12'h000;
            hold_d = 32'h0000_0000;
         end
      end
      always_ff @(posedge hclk or negedge hresetn) begin
         if (!hresetn) begin
            cnt_q  <= 32'h0000_0000;
            per_q  <= 32'h0000_0000;
            tdiv_q <= 12'h000;
            hold_q <= 32'h0000_0000;
         end else begin
            cnt_q  <= cnt_d;
            per_q  <= per_d;
            tdiv_q <= tdiv_d;
            hold_q <= hold_d;
         end
      end
      assign hold_w[i] = hold_q;
   end
   ////////////////////////////////////////////////////////////////////////////
   // Scan sequencer, setpoint search and output port
   sample_t smp_in;
   assign smp_in = '{chan: 3'(seq_q), value: hold_w[seq_q]};
   assign push   = busy_q & in_rdy;
   // Priority search over the channel's setpoints on the 16-bit sample
   always_comb begin
      logic [15:0] v;
      lim_t        l;
      spc_t        c;
      logic        hit;
      v     = hold_w[seq_q][15:0];
      l     = '0;
      c     = '0;
      hit   = 1'b0;
      m_hit = 1'b0;
      m_spc = '0;
      for (int s = NSP - 1; s >= 0; s--) begin
         l = lim_q[{seq_q, SW'(s)}];
         c = spc_q[{seq_q, SW'(s)}];
         case (c.kind)
            SP_GT:   hit = v > l.lo;
            SP_LT:   hit = v < l.lo;
            SP_IN:   hit = (v > l.lo) && (v < l.hi);
            SP_OUT:  hit = (v < l.lo) || (v > l.hi);
            default: hit = 1'b0;
         endcase
         if (c.en && hit) begin
            m_hit = 1'b1;
            m_spc = c;
         end
      end
   end
   always_comb begin
      busy_d  = busy_q;
      seq_d   = seq_q;
      mark_d  = mark_q;
      dport_d = dport_q;
      if (do_wr && wa_q == DPORT_OFS) begin
         dport_d = hwdata[7:0];
      end
      if (push) begin
         // Marker only moves as a sample enters the stream or when acquisition begins
         mark_d[seq_q] = m_hit;
         if (m_hit && osel_q[seq_q]) begin
            dport_d = (dport_d & ~m_spc.dmask) | (m_spc.dval & m_spc.dmask);
         end
         busy_d = (seq_q != CW'(NCH - 1));
         seq_d  = seq_q + CW'(1);
      end
      // A new scan restarts the walk; samples of the old one not yet in the buffer are dropped
      if (scan_ev) begin
         busy_d = 1'b1;
         seq_d  = '0;
      end
      if (acq_q) begin
         busy_d = 1'b0;
         seq_d  = '0;
         mark_d = '0;
      end
   end
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         busy_q  <= 1'b0;
         seq_q   <= '0;
         mark_q  <= '0;
         dport_q <= 8'h00;
      end else begin
         busy_q  <= busy_d;
         seq_q   <= seq_d;
         mark_q  <= mark_d;
         dport_q <= dport_d;
      end
   end
   // Stall by the main unit holds the sequencer, so no sample is lost
   sample_buf #(
      .DEPTH (2)
   ) u_buf (
      .hclk      (hclk),
      .hresetn   (hresetn),
      .in_valid  (busy_q),
      .in_ready  (in_rdy),
      .in_data   (smp_in),
      .out_valid (smp_valid),
      .out_ready (smp_ready),
      .out_data  (smp_data)
   );
   // Open drain: a set port bit turns the sink on and pulls the pin low
   assign channel_match_marker = mark_q;
   assign dport_o              = 8'h00;
   assign dport_oe_n           = ~dport_q;
endmodule : updn_counter

// file: shared/updn_cnt_pkg.sv
// Shared constants, register map and carrier types of the up/down counter block
package updn_cnt_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Register byte offsets
   localparam logic [11:0] CTRL_OFS  = 12'h000; // W bit0 begin acquisition, R bit1 busy
   localparam logic [11:0] OSEL_OFS  = 12'h004; // Channels allowed to update the port
   localparam logic [11:0] DPORT_OFS = 12'h008; // Digital output port byte
   localparam logic [11:0] MARK_OFS  = 12'h00C; // Match markers, read only
   localparam logic [11:0] CFG_BASE  = 12'h100; // Channel config, 4 bytes per channel
   localparam logic [11:0] HOLD_BASE = 12'h140; // Latched values, read only
   localparam logic [11:0] LIM_BASE  = 12'h400; // Setpoint limits, ch*16+sp words
   localparam logic [11:0] SPC_BASE  = 12'h600; // Setpoint controls, ch*16+sp words
   localparam int          ACQ_BIT   = 0;
   localparam int          BUSY_BIT  = 1;

   ////////////////////////////////////////////////////////////////////////////
   // Timing
   localparam int CLK_NS      = 10;
   localparam int TICK0_NS    = 200;
   localparam int TICK1_NS    = 2000;
   localparam int TICK2_NS    = 20000;
   localparam int TICK0_CYC   = (TICK0_NS / CLK_NS < 1) ? 1 : TICK0_NS / CLK_NS;
   localparam int TICK1_CYC   = (TICK1_NS / CLK_NS < 1) ? 1 : TICK1_NS / CLK_NS;
   localparam int TICK2_CYC   = (TICK2_NS / CLK_NS < 1) ? 1 : TICK2_NS / CLK_NS;

   ////////////////////////////////////////////////////////////////////////////
   // Field encodings
   localparam logic [1:0] MODE_OFF = 2'h0;
   localparam logic [1:0] MODE_ENC = 2'h1; // Up/down counting
   localparam logic [1:0] MODE_PER = 2'h2; // Period measurement
   localparam logic [1:0] MODE_TOT = 2'h3; // Totalize
   localparam logic [1:0] MULT_1X  = 2'h0;
   localparam logic [1:0] MULT_2X  = 2'h1;
   localparam logic [1:0] SP_GT    = 2'h0;
   localparam logic [1:0] SP_LT    = 2'h1;
   localparam logic [1:0] SP_IN    = 2'h2;
   localparam logic [1:0] SP_OUT   = 2'h3;

   // Channel configuration word, reset value all zero
   typedef struct packed {
      logic [16:0] rsvd;
      logic        gate_en;   // Period: count ticks only while routed source high
      logic [1:0]  tick_sel;  // 0: 200 ns, 1: 2000 ns, else 20000 ns
      logic        stop_top;  // Totalize holds at maximum
      logic        latch_en;  // Capture value on scan begin
      logic [3:0]  map_sel;   // 0-7 channel input, 8-15 channel match marker
      logic        clr_map;   // Up/down: routed source clears the counter
      logic [1:0]  mult;      // Counts per input cycle: 1X, 2X, 4X
      logic        wide;      // 32-bit counter, else 16-bit
      logic [1:0]  mode;
   } cfg_t;

   // Setpoint limits and controls
   typedef struct packed {
      logic [15:0] hi;
      logic [15:0] lo;
   } lim_t;

   typedef struct packed {
      logic [12:0] rsvd;
      logic [7:0]  dmask;
      logic [7:0]  dval;
      logic        en;
      logic [1:0]  kind;
   } spc_t;

   // One word of the acquisition stream
   typedef struct packed {
      logic [2:0]  chan;
      logic [31:0] value;
   } sample_t;

endpackage : updn_cnt_pkg

// file: rtl/sample_buf.sv
// Small valid/ready buffer for the sample stream
`timescale 1ns/100ps
module sample_buf
   import updn_cnt_pkg::*;
#(
   parameter int DEPTH = 2
) (
   // Clock and reset
   input  wire logic hclk,
   input  wire logic hresetn,
   // Fill side
   input  wire logic    in_valid,
   output      logic    in_ready,
   input  wire sample_t in_data,
   // Drain side
   output      logic    out_valid,
   input  wire logic    out_ready,
   output      sample_t out_data
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   sample_t         mem_q [DEPTH];
   logic [AW-1:0]   wr_q, wr_d, rd_q, rd_d;
   logic [AW:0]     cnt_q, cnt_d;
   logic            push, pop;

   // Honest full and empty straight from the fill count
   assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
   assign out_valid = (cnt_q != '0);
   assign out_data  = mem_q[rd_q];
   assign push      = in_valid & in_ready;
   assign pop       = out_valid & out_ready;

   // Pointer and count next values
   always_comb begin
      wr_d  = push ? ((wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + AW'(1)) : wr_q;
      rd_d  = pop  ? ((rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + AW'(1)) : rd_q;
      cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_q  <= '0;
         rd_q  <= '0;
         cnt_q <= '0;
      end else begin
         wr_q  <= wr_d;
         rd_q  <= rd_d;
         cnt_q <= cnt_d;
      end
   end

   // Storage has no reset; empty flag guards it
   always_ff @(posedge hclk) begin
      if (push) begin
         mem_q[wr_q] <= in_data;
      end
   end

endmodule : sample_buf

// file: bench/updn_counter_checker.sv
// Port assertions for the up/down counter block
`timescale 1ns/100ps
module updn_counter_checker
   import updn_cnt_pkg::*;
#(
   parameter int NCH = 8,
   parameter int NSP = 16
) (
   // Clock and reset
   input wire logic           hclk,
   input wire logic           hresetn,
   // Bus request
   input wire logic           hsel,
   input wire logic [1:0]     htrans,
   input wire logic           hwrite,
   // Scan and stream
   input wire logic           scan_begin_pulse,
   input wire logic           smp_valid,
   input wire logic           smp_ready,
   input wire sample_t        smp_data,
   // Markers and port
   input wire logic [NCH-1:0] channel_match_marker,
   input wire logic [7:0]     dport_o,
   input wire logic [7:0]     dport_oe_n
);
   logic [7:0] since_q, since_d;
   logic [3:0] hs_q, hs_d;
   logic [2:0] nxt_q, nxt_d;
   logic       hs;

   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);

   ////////////////////////////////////////
   // Quiet time since a scan or bus write, words and next channel per scan
   assign hs = smp_valid && smp_ready;
   always_comb begin
      since_d = (since_q == 8'hFF) ? since_q : since_q + 8'h01;
      hs_d = hs ? hs_q + 4'h1 : hs_q;
      nxt_d = hs ? smp_data.chan + 3'h1 : nxt_q;
      if (scan_begin_pulse || (hsel && htrans[1] && hwrite)) begin
         since_d = 8'h00;
      end
      if (scan_begin_pulse) begin
         hs_d = 4'h0;
         nxt_d = 3'h0;
      end
   end

   // Helper registers
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         since_q <= 8'h00;
         hs_q <= 4'h0;
         nxt_q <= 3'h0;
      end else begin
         since_q <= since_d;
         hs_q <= hs_d;
         nxt_q <= nxt_d;
      end
   end

   ////////////////////////////////////////
   // Stream handshake steps
   sequence handshake_s;
      smp_valid && smp_ready;
   endsequence
   sequence scan_rise_s;
      $rose(scan_begin_pulse);
   endsequence

   held_word_a:
   assert property (smp_valid && !smp_ready |=> smp_valid && $stable(smp_data))
      else $error("stream word changed before taken");
   scan_start_a:
   assert property (scan_rise_s |-> ##[1:30] smp_valid)
      else $error("no sample after scan begin");
   chan_order_a:
   assert property (handshake_s |-> smp_data.chan == nxt_q || smp_data.chan == 3'h0)
      else $error("sample channel out of order");
   burst_len_a:
   assert property (hs_q <= 4'h8)
      else $error("more than eight samples per scan");
   scan_quiet_a:
   assert property (since_q == 8'hFF |-> !smp_valid)
      else $error("sample without scan");
   marker_paced_a:
   assert property ($changed(channel_match_marker) |-> since_q < 8'hC8)
      else $error("marker moved without a sample");
   port_paced_a:
   assert property ($changed(dport_oe_n) |-> since_q < 8'hC8)
      else $error("port moved without a sample");
   drain_only_a:
   assert property (dport_o == 8'h00)
      else $error("port pin driven high");
endmodule : updn_counter_checker

bind updn_counter updn_counter_checker #(.NCH(NCH), .NSP(NSP)) updn_counter_checker_inst (
   .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
   .scan_begin_pulse(scan_begin_pulse), .smp_valid(smp_valid), .smp_ready(smp_ready),
   .smp_data(smp_data), .channel_match_marker(channel_match_marker),
   .dport_o(dport_o), .dport_oe_n(dport_oe_n)
);

// file: bench/acq_host_model.sv
// Acquisition main unit model: scan pulses and sample sink
`timescale 1ns/100ps
module acq_host_model
   import updn_cnt_pkg::*;
(
   // Clock and reset
   input  wire logic    hclk,
   input  wire logic    hresetn,
   // Bench commands
   input  wire logic    scan_req,
   input  wire logic    slow,
   // Scan pulse and stream
   output      logic    scan_begin_pulse,
   input  wire logic    smp_valid,
   output      logic    smp_ready,
   input  wire sample_t smp_data
);
   sample_t    got_q[$];
   logic [1:0] hold_q;
   logic [1:0] cyc_q;

   ////////////////////////////////////////
   // Pulse held three cycles, since the block synchronises it
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hold_q <= 2'h0;
         cyc_q <= 2'h0;
         scan_begin_pulse <= 1'b0;
         smp_ready <= 1'b0;
      end else begin
         hold_q <= scan_req ? 2'h2 : (hold_q != 2'h0) ? hold_q - 2'h1 : 2'h0;
         scan_begin_pulse <= scan_req || hold_q != 2'h0;
         cyc_q <= cyc_q + 2'h1;
         // A slow sink takes one word in four, filling the buffer
         smp_ready <= !slow || cyc_q == 2'h0;
         if (smp_valid && smp_ready) begin
            got_q.push_back(smp_data);
         end
      end
   end
endmodule : acq_host_model

// file: bench/updn_counter_bench.sv
// Self-checking bench of the up/down counter block
`timescale 1ns/100ps
module updn_counter_bench
   import updn_cnt_pkg::*;
;
   logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
   logic        smp_valid, smp_ready, scan_begin_pulse, scan_req, slow;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic [31:0] haddr, hwdata, hrdata, rd, last, e;
   logic [7:0]  ch_in, channel_match_marker, dport_o, dport_oe_n;
   sample_t     smp_data;
   cfg_t        c;
   int          errors, cmp_count, seed, mdl, n, m;

   ////////////////////////////////////////
   // Clock
   initial begin
      hclk = 1'b0;
      forever #5 hclk = ~hclk;
   end

   // Design, and the main unit on the far side
   updn_counter updn_counter_inst (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .ch_in(ch_in),
      .scan_begin_pulse(scan_begin_pulse), .smp_valid(smp_valid), .smp_ready(smp_ready),
      .smp_data(smp_data), .channel_match_marker(channel_match_marker),
      .dport_o(dport_o), .dport_oe_n(dport_oe_n)
   );
   acq_host_model acq_host_model_inst (
      .hclk(hclk), .hresetn(hresetn), .scan_req(scan_req), .slow(slow),
      .scan_begin_pulse(scan_begin_pulse), .smp_valid(smp_valid),
      .smp_ready(smp_ready), .smp_data(smp_data)
   );

   ////////////////////////////////////////
   // Verdict and end of run
   task automatic conclude;
      $display("errors %0d compares %0d", errors, cmp_count);
      if (errors == 0 && cmp_count > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : conclude

   // Word compare
   task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] got);
      cmp_count++;
      if (got !== x) begin
         errors++;
         $display("unexpected %s: expected %h seen %h", nm, x, got);
      end
   endtask : chk

   // Wait for ready under a bound
   task automatic rdy_wait;
      int k;
      k = 0;
      do begin
         @(posedge hclk);
         k++;
      end while (hreadyout !== 1'b1 && k < 50);
      if (k >= 50) begin
         errors++;
         conclude();
      end
   endtask : rdy_wait

   // One AHB-Lite single word transfer
   task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] wd);
      hsel <= 1'b1;
      htrans <= 2'b10;
      hwrite <= wr;
      haddr <= {20'h00000, a};
      rdy_wait();
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= wd;
      rdy_wait();
      rd = hrdata;
      if (wr && a == CTRL_OFS) begin
         repeat (2) @(posedge hclk); // Clear lands a cycle after the write
      end
   endtask : bus

   task automatic rdv(input logic [11:0] a, input logic [31:0] x, input string nm);
      bus(1'b0, a, 32'h0);
      chk(nm, x, rd);
   endtask : rdv

   // Channel 0 pulses, long enough for the input synchroniser
   task automatic pulses(input int cnt);
      repeat (cnt) begin
         ch_in[0] <= 1'b1;
         repeat (4) @(posedge hclk);
         ch_in[0] <= 1'b0;
         repeat (4) @(posedge hclk);
      end
   endtask : pulses

   // One scan; all eight samples must arrive in channel order
   task automatic scan;
      int k, b;
      b = acq_host_model_inst.got_q.size();
      scan_req <= 1'b1;
      @(posedge hclk);
      scan_req <= 1'b0;
      k = 0;
      while (acq_host_model_inst.got_q.size() < b + 8 && k < 400) begin
         @(posedge hclk);
         k++;
      end
      if (k >= 400) begin
         errors++;
         conclude();
      end
      for (k = 0; k < 8; k++) begin
         chk("sample chan", 32'(k), 32'(acq_host_model_inst.got_q[b+k].chan));
      end
      last = acq_host_model_inst.got_q[b].value;
   endtask : scan

   // Setpoint control word: greater-than, enabled, two low port bits
   function automatic logic [31:0] spw(input logic [7:0] v);
      spc_t s;
      s = '0;
      s.dmask = 8'h03;
      s.dval = v;
      s.en = 1'b1;
      s.kind = SP_GT;
      return s;
   endfunction : spw

   ////////////////////////////////////////
   // Main sequence
   initial begin
      errors = 0;
      cmp_count = 0;
      seed = 39;
      hresetn = 1'b0;
      {hsel, hwrite, scan_req, slow} = 4'h0;
      htrans = 2'b00;
      hsize = 3'b010;
      haddr = 32'h0;
      hwdata = 32'h0;
      ch_in = 8'h00;
      repeat (12) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      chk("stream valid", 32'h0, 32'(smp_valid));
      chk("port enables", 32'hFF, 32'(dport_oe_n));
      chk("response", 32'h0, 32'(hresp));
      rdv(CFG_BASE, 32'h0, "cfg0");
      rdv(12'h0F0, 32'h0, "unmapped");
      // Up then down past zero, per width and multiplier
      for (int w = 0; w < 2; w++) begin
         for (int x = 0; x < 3; x++) begin
            bus(1'b1, CTRL_OFS, 32'h1);
            rdv(HOLD_BASE, 32'h0, "cleared count");
            c = '0;
            c.mode = MODE_ENC;
            c.wide = w[0];
            c.mult = 2'(x);
            bus(1'b1, CFG_BASE, c);
            n = 1 + ($random(seed) & 15);
            m = n + 1 + ($random(seed) & 7);
            // 4X also counts the direction line's rise, already downward
            mdl = (x == 2) ? 2 * (n - m) - 1 : (n - m) * (x + 1);
            e = w ? 32'(mdl) : 32'(mdl & 32'hFFFF);
            ch_in[1] <= 1'b0;
            repeat (4) @(posedge hclk);
            pulses(n);
            ch_in[1] <= 1'b1;
            repeat (4) @(posedge hclk);
            pulses(m);
            ch_in[1] <= 1'b0;
            rdv(HOLD_BASE, e, "live count");
         end
      end
      // Latched value under a slow sink
      slow <= 1'b1;
      bus(1'b1, CTRL_OFS, 32'h1);
      c.mode = MODE_TOT;
      c.stop_top = 1'b1;
      c.wide = 1'b0;
      c.mult = MULT_1X;
      c.latch_en = 1'b1;
      bus(1'b1, CFG_BASE, c);
      n = 1 + ($random(seed) & 7);
      pulses(n);
      scan();
      chk("ch0 sample", 32'(n), last);
      pulses(3);
      rdv(HOLD_BASE, 32'(n), "latched hold");
      slow <= 1'b0;
      // Own marker clears the counter: rollover above five
      bus(1'b1, CTRL_OFS, 32'h1);
      bus(1'b1, OSEL_OFS, 32'h1);
      bus(1'b1, LIM_BASE, 32'h5);
      bus(1'b1, LIM_BASE + 12'h004, 32'h5);
      bus(1'b1, SPC_BASE, spw(8'h01));
      bus(1'b1, SPC_BASE + 12'h004, spw(8'h02));
      c.mode = MODE_ENC;
      c.clr_map = 1'b1;
      c.map_sel = 4'h8;
      bus(1'b1, CFG_BASE, c);
      pulses(7);
      scan();
      chk("past limit", 32'h7, last);
      chk("marker high", 32'h1, 32'(channel_match_marker[0]));
      chk("first match port", 32'hFE, 32'(dport_oe_n));
      scan();
      chk("rolled over", 32'h0, last);
      chk("marker low", 32'h0, 32'(channel_match_marker[0]));
      // No channel selected: marker moves, port stays
      bus(1'b1, DPORT_OFS, 32'h0);
      bus(1'b1, OSEL_OFS, 32'h0);
      pulses(7);
      scan();
      chk("marker again", 32'h1, 32'(channel_match_marker[0]));
      chk("port unselected", 32'hFF, 32'(dport_oe_n));
      bus(1'b1, CTRL_OFS, 32'h1);
      rdv(MARK_OFS, 32'h0, "markers cleared");
      conclude();
   end
endmodule : updn_counter_bench
